/* hdl/aso_serial_ctrl.sv */
// Serial output format control, start-up sequence and digital reset of the converter.
// Assumes one sample strobe per sample clock and one bit tick per output clock edge.
module aso_serial_ctrl #(
  parameter int SETTLE_SAMPLES = aso_pkg::SETTLE_SAMPLES
) (
  input  wire logic        mclk_in,
  input  wire logic        rst_in,
  input  wire logic        sclk_in,
  input  wire logic        csb_n_in,
  input  wire logic        sdio_in,
  output logic             sdio_out,
  output logic             sdio_oe_out,
  input  wire logic        sample_strobe_in,
  input  wire logic [15:0] sample_data_in,
  input  wire logic        bit_tick_in,
  output logic             lane0_out,
  output logic             lane1_out,
  output logic             frame_out,
  output logic             bit_clock_output_out,
  output logic [3:0]       clock_mult_out,
  output logic             datapath_reset_out,
  output logic             common_mode_voltage_pd_out
);

  typedef struct packed {
    aso_pkg::aso_state_t state;
    logic [21:0]         count;
    logic [7:0]          pm;
    logic [7:0]          fmt;
    logic [7:0]          cm;
    logic [7:0]          act_fmt;
    logic [15:0]         sample;
    logic [15:0]         word;
    logic [3:0]          slot;
    logic                phase;
    logic                lane0;
    logic                lane1;
    logic                frame;
    logic                bclk;
  } aso_ctrl_t;

  aso_ctrl_t   r;
  aso_ctrl_t   next_r;
  logic        wr_stb;
  logic [12:0] addr;
  logic [7:0]  wdata;
  logic [7:0]  rdata;
  logic        zero_out;
  logic        adv;

  aso_spi_port i_aso_spi_port (
    .mclk_in     (mclk_in),
    .rst_in      (rst_in),
    .sclk_in     (sclk_in),
    .csb_n_in    (csb_n_in),
    .sdio_in     (sdio_in),
    .sdio_out    (sdio_out),
    .sdio_oe_out (sdio_oe_out),
    .wr_stb_out  (wr_stb),
    .addr_out    (addr),
    .wdata_out   (wdata),
    .rdata_in    (rdata)
  );

  // ==========================================================================
  // Format decoding
  function automatic logic [3:0] last_slot(input logic [7:0] f);
    last_slot = f[aso_pkg::FMT_ONE_LANE] ? 4'hF : 4'h7;
  endfunction : last_slot

  function automatic logic [1:0] lane_bits(input logic [7:0] f, input logic [15:0] w,
                                           input logic [3:0] s);
    if (f[aso_pkg::FMT_ONE_LANE]) begin
      lane_bits = {w[4'hF - s], 1'b0};
    end else if (f[aso_pkg::FMT_BYTEWISE]) begin
      lane_bits = {w[4'hF - s], w[4'h7 - s]};
    end else begin
      lane_bits = {w[4'hF - {s[2:0], 1'b0}], w[4'hE - {s[2:0], 1'b0}]};
    end
  endfunction : lane_bits

  always_comb begin
    case (addr)
      aso_pkg::ADDR_POWER_MODE: rdata = r.pm;
      aso_pkg::ADDR_OUT_FORMAT: rdata = r.fmt;
      aso_pkg::ADDR_CM_GEN:     rdata = r.cm;
      default:                  rdata = 8'h00;
    endcase
  end

  // Output is all zero except in normal running with normal power mode.
  assign zero_out = (r.state != aso_pkg::ST_RUN) || (r.pm[1:0] != aso_pkg::PM_NORMAL);
  // Single data rate moves one bit per full output clock, so every second tick.
  assign adv = bit_tick_in && (r.act_fmt[aso_pkg::FMT_DDR] || r.act_fmt[aso_pkg::FMT_ONE_LANE]
                               || r.phase);

  // ==========================================================================
  // Next state
  always_comb begin
    logic [1:0] bits;
    logic [3:0] half;
    logic [3:0] last;
    bits   = 2'h0;
    half   = 4'h0;
    last   = last_slot(r.act_fmt);
    next_r = r;
    if (wr_stb) begin
      case (addr)
        aso_pkg::ADDR_POWER_MODE: next_r.pm = wdata & aso_pkg::PM_WRITE_MASK;
        aso_pkg::ADDR_OUT_FORMAT: next_r.fmt = wdata;
        aso_pkg::ADDR_CM_GEN:     next_r.cm = wdata & aso_pkg::CM_WRITE_MASK;
        default:                  next_r.pm = r.pm;
      endcase
    end
    if (sample_strobe_in) begin
      next_r.sample = sample_data_in;
    end
    case (r.state)
      aso_pkg::ST_INIT: begin
        if (sample_strobe_in) begin
          next_r.count = r.count + 22'h000001;
          if (r.count == 22'(aso_pkg::INIT_SAMPLES - 1)) begin
            next_r.state = aso_pkg::ST_RUN;
          end
        end
      end
      aso_pkg::ST_RUN: begin
        next_r.count = 22'h000000;
      end
      aso_pkg::ST_DRST: begin
        next_r.count = 22'h000000;
        if (r.pm[1:0] != aso_pkg::PM_DRESET) begin
          next_r.state = aso_pkg::ST_SETTLE;
        end
      end
      aso_pkg::ST_SETTLE: begin
        if (sample_strobe_in) begin
          next_r.count = r.count + 22'h000001;
          if (r.count == 22'(SETTLE_SAMPLES - 1)) begin
            next_r.state = aso_pkg::ST_RUN;
          end
        end
      end
      default: begin
        next_r.state = aso_pkg::ST_INIT;
        next_r.count = 22'h000000;
      end
    endcase
    // A reset may be re-armed at any time, also during settling or start-up.
    if (r.pm[1:0] == aso_pkg::PM_DRESET) begin
      next_r.state = aso_pkg::ST_DRST;
    end
    if (bit_tick_in) begin
      next_r.phase = ~r.phase;
      next_r.bclk  = ~r.bclk;
    end
    if (adv) begin
      next_r.phase = 1'b0;
      bits = lane_bits(r.act_fmt, r.word, r.slot);
      next_r.lane0 = zero_out ? 1'b0 : bits[1];
      next_r.lane1 = zero_out ? 1'b0 : bits[0];
      half = {1'b0, last[3:1]} + 4'h1;
      if (r.act_fmt[aso_pkg::FMT_FRAME_2X]) begin
        next_r.frame = (r.slot & (half - 4'h1)) < {1'b0, half[3:1]};
      end else begin
        next_r.frame = r.slot < half;
      end
      if (r.slot == last_slot(r.act_fmt)) begin
        // Picking up the format only here keeps a word from mixing two formats.
        next_r.slot    = 4'h0;
        next_r.act_fmt = r.fmt;
        next_r.word    = zero_out ? 16'h0000 : r.sample;
      end else begin
        next_r.slot = r.slot + 4'h1;
      end
    end
    // Lanes drop at once in digital reset rather than waiting for the next bit tick.
    if (r.pm[1:0] == aso_pkg::PM_DRESET) begin
      next_r.lane0 = 1'b0;
      next_r.lane1 = 1'b0;
    end
  end

  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      r         <= '0;
      r.state   <= aso_pkg::ST_INIT;
      r.pm      <= aso_pkg::PM_RESET;
      r.fmt     <= aso_pkg::FMT_RESET;
      r.act_fmt <= aso_pkg::FMT_RESET;
      r.cm      <= aso_pkg::CM_RESET;
    end else begin
      r <= next_r;
    end
  end

  assign lane0_out                  = r.lane0;
  assign lane1_out                  = r.lane1;
  assign frame_out                  = r.frame;
  assign bit_clock_output_out       = r.bclk;
  assign clock_mult_out             = (r.act_fmt[aso_pkg::FMT_DDR] &&
                                       !r.act_fmt[aso_pkg::FMT_ONE_LANE]) ?
                                      aso_pkg::MULT_4X : aso_pkg::MULT_8X;
  assign datapath_reset_out         = (r.state == aso_pkg::ST_DRST);
  assign common_mode_voltage_pd_out = r.cm[aso_pkg::CM_PD_BIT];

  // ==========================================================================
  // Assertions
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (rst_in);

  sequence s_release;
    (r.state == aso_pkg::ST_DRST) && (r.pm[1:0] != aso_pkg::PM_DRESET);
  endsequence

  sequence s_settle_zero;
    (r.state == aso_pkg::ST_SETTLE) ##1 (!lane0_out && !lane1_out);
  endsequence

  a_fmt_reset_value: assert property ($past(rst_in) |-> r.fmt == 8'h30)
    else $error("Format register not at its reset value.");
  a_init_after_reset: assert property ($past(rst_in) |-> r.state == aso_pkg::ST_INIT)
    else $error("Start-up sequence not entered after reset.");
  a_fmt_write_now: assert property (wr_stb && addr == aso_pkg::ADDR_OUT_FORMAT
                                    |=> r.fmt == $past(wdata))
    else $error("Format write did not apply at once.");
  a_cm_power_down: assert property (wr_stb && addr == aso_pkg::ADDR_CM_GEN
                                    |=> common_mode_voltage_pd_out == $past(wdata[3]))
    else $error("Common-mode power-down bit not applied.");
  a_dreset_holds: assert property (r.pm[1:0] == aso_pkg::PM_DRESET
                                   |=> datapath_reset_out ##1 (!lane0_out && !lane1_out))
    else $error("Digital reset did not hold the datapath.");
  a_release_settles: assert property (s_release |=> s_settle_zero)
    else $error("Release did not enter a zero-output settle.");
  a_fmt_at_boundary: assert property (!(adv && r.slot == last_slot(r.act_fmt))
                                      |=> $stable(r.act_fmt))
    else $error("Active format changed inside a word.");
  a_word_slots: assert property (adv |=> r.slot == (($past(r.slot) ==
                                  last_slot($past(r.act_fmt))) ? 4'h0 : $past(r.slot) + 4'h1))
    else $error("Bit slot sequence does not span one 16-bit word.");

endmodule : aso_serial_ctrl

/* shared/aso_pkg.sv */
// Shared constants for the serial output format and digital reset control block.
// Assumes the register port carries 13-bit addresses and 8-bit data words.
package aso_pkg;

  // ==========================================================================
  // Register map
  localparam logic [12:0] ADDR_POWER_MODE = 13'h0008;
  localparam logic [12:0] ADDR_OUT_FORMAT = 13'h0021;
  localparam logic [12:0] ADDR_CM_GEN     = 13'h0102;

  // ==========================================================================
  // Reset values and fields
  localparam logic [7:0] FMT_RESET      = 8'h30;
  localparam logic [7:0] PM_RESET       = 8'h00;
  localparam logic [7:0] CM_RESET       = 8'h00;
  localparam logic [7:0] PM_WRITE_MASK  = 8'h23;
  localparam logic [7:0] CM_WRITE_MASK  = 8'h08;
  localparam logic [1:0] PM_NORMAL      = 2'h0;
  localparam logic [1:0] PM_DRESET      = 2'h3;
  localparam int         CM_PD_BIT      = 3;
  localparam int         FMT_ONE_LANE   = 6;
  localparam int         FMT_DDR        = 5;
  localparam int         FMT_BYTEWISE   = 4;
  localparam int         FMT_FRAME_2X   = 2;

  // ==========================================================================
  // Counts, in sample clock cycles or port clock bits; clock multipliers
  localparam int         INIT_SAMPLES   = 16;
  localparam int         SETTLE_SAMPLES = 2900000;
  localparam int         INSTR_BITS     = 16;
  localparam int         DATA_BITS      = 8;
  localparam logic [3:0] MULT_4X        = 4'h4;
  localparam logic [3:0] MULT_8X        = 4'h8;

  // ==========================================================================
  // Control states
  typedef enum logic [3:0] {
    ST_INIT   = 4'b0001,
    ST_RUN    = 4'b0010,
    ST_DRST   = 4'b0100,
    ST_SETTLE = 4'b1000
  } aso_state_t;

endpackage : aso_pkg

/* hdl/aso_spi_port.sv */
// Serial configuration port: samples the three port pins with the block clock.
// Assumes clock low when idle, data taken on the rising edge, read data on falling.
module aso_spi_port (
  input  wire logic        mclk_in,
  input  wire logic        rst_in,
  input  wire logic        sclk_in,
  input  wire logic        csb_n_in,
  input  wire logic        sdio_in,
  output logic             sdio_out,
  output logic             sdio_oe_out,
  output logic             wr_stb_out,
  output logic [12:0]      addr_out,
  output logic [7:0]       wdata_out,
  input  wire logic [7:0]  rdata_in
);

  typedef struct packed {
    logic [2:0]  sck;
    logic [2:0]  csb;
    logic [2:0]  dio;
    logic        sck_f;
    logic        csb_f;
    logic [15:0] shift;
    logic [4:0]  count;
    logic        rd;
    logic        load;
    logic [7:0]  rsh;
    logic [12:0] addr;
    logic [7:0]  wdata;
    logic        wr_stb;
    logic        dout;
    logic        oe;
  } aso_spi_t;

  aso_spi_t r;
  aso_spi_t next_r;

  // ==========================================================================
  // Next state
  always_comb begin
    next_r        = r;
    next_r.wr_stb = 1'b0;
    next_r.load   = 1'b0;
    // Three stages; a level counts once the second and third agree.
    next_r.sck = {r.sck[1:0], sclk_in};
    next_r.csb = {r.csb[1:0], csb_n_in};
    next_r.dio = {r.dio[1:0], sdio_in};
    if (r.sck[1] == r.sck[2]) begin
      next_r.sck_f = r.sck[2];
    end
    if (r.csb[1] == r.csb[2]) begin
      next_r.csb_f = r.csb[2];
    end
    if (r.csb_f) begin
      next_r.count = 5'h00;
      next_r.oe    = 1'b0;
      next_r.rd    = 1'b0;
    end else if (next_r.sck_f && !r.sck_f) begin
      next_r.shift = {r.shift[14:0], r.dio[2]};
      if (r.count != 5'(aso_pkg::INSTR_BITS + aso_pkg::DATA_BITS)) begin
        next_r.count = r.count + 5'h01;
      end
      if (r.count == 5'(aso_pkg::INSTR_BITS - 1)) begin
        next_r.rd   = r.shift[14];
        next_r.addr = {r.shift[11:0], r.dio[2]};
        next_r.load = r.shift[14];
      end
      if (r.count == 5'(aso_pkg::INSTR_BITS + aso_pkg::DATA_BITS - 1) && !r.rd) begin
        next_r.wdata  = {r.shift[6:0], r.dio[2]};
        next_r.wr_stb = 1'b1;
      end
    end else if (!next_r.sck_f && r.sck_f && r.rd) begin
      next_r.dout = r.rsh[7];
      next_r.rsh  = {r.rsh[6:0], 1'b0};
      next_r.oe   = 1'b1;
    end
    if (r.load) begin
      next_r.rsh = rdata_in;
    end
  end

  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      r       <= '0;
      r.sck_f <= 1'b0;
      r.csb_f <= 1'b1;
      r.csb   <= 3'h7;
    end else begin
      r <= next_r;
    end
  end

  assign sdio_out    = r.dout;
  assign sdio_oe_out = r.oe;
  assign wr_stb_out  = r.wr_stb;
  assign addr_out    = r.addr;
  assign wdata_out   = r.wdata;

endmodule : aso_spi_port

/* verif/aso_capture_model.sv */
// Capture side model: rebuilds sample words from the two serial lanes.
// Assumes its format input mirrors the format register of the sender.
module aso_capture_model (
  input  wire logic        mclk_in,
  input  wire logic        rst_in,
  input  wire logic        tick_in,
  input  wire logic [7:0]  fmt_in,
  input  wire logic        lane0_in,
  input  wire logic        lane1_in,
  input  wire logic        frame_in,
  output logic [15:0]      word_out,
  output logic [15:0]      count_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic        tick_d;
  logic        phase;
  logic        frame_d;
  logic [4:0]  cnt;
  logic [15:0] sh0;
  logic [15:0] sh1;
  logic [15:0] w;
  logic        sdr;
  logic        one;
  logic [4:0]  half;
  assign sdr  = !fmt_in[aso_pkg::FMT_DDR] && !fmt_in[aso_pkg::FMT_ONE_LANE];
  assign one  = fmt_in[aso_pkg::FMT_ONE_LANE];
  assign half = one ? 5'h08 : 5'h04;
  // ====
  // Word decode
  always_comb begin
    w = sh0;
    if (!one && fmt_in[aso_pkg::FMT_BYTEWISE]) begin
      w = {sh0[7:0], sh1[7:0]};
    end else if (!one) begin
      for (int i = 0; i < 8; i++) begin
        w[2*i+:2] = {sh0[i], sh1[i]};
      end
    end
  end
  // ====
  // Slot capture
  // In single rate each slot stands for two ticks, so either tick phase sees it.
  // A second frame pulse in mid word is skipped in the 2x frame mode.
  always @(posedge mclk_in) begin
    tick_d <= tick_in;
    if (rst_in) begin
      phase     <= 1'b0;
      frame_d   <= 1'b0;
      cnt       <= 5'h1F;
      count_out <= 16'h0000;
      word_out  <= 16'h0000;
    end else if (tick_d && !(sdr && phase)) begin
      phase   <= sdr;
      frame_d <= frame_in;
      sh0     <= {sh0[14:0], lane0_in};
      sh1     <= {sh1[14:0], lane1_in};
      if (frame_in && !frame_d && !(fmt_in[aso_pkg::FMT_FRAME_2X] && cnt == half)) begin
        word_out  <= w;
        count_out <= count_out + 16'h0001;
        cnt       <= 5'h01;
      end else if (cnt != 5'h1F) begin
        cnt <= cnt + 5'h01;
      end
    end else if (tick_d) begin
      phase <= 1'b0;
    end
  end
endmodule : aso_capture_model

/* verif/tb_aso_serial_ctrl.sv */
// Bench for the serial output format and digital reset control block.
// Assumes the capture model is told each format written through the port before its words are checked.
module tb_aso_serial_ctrl;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int SETTLE = 20;
  typedef struct packed {logic [7:0] fmt; logic [15:0] data; logic [3:0] mult;} aso_row_t;
  // Mid-word frame pulses cannot mark word starts, so 2x rows use rotation-proof data.
  aso_row_t rows [9] = '{
    '{8'h20, 16'hC3A5, 4'h4}, '{8'h10, 16'h5A0F, 4'h8}, '{8'h00, 16'h96E1, 4'h8},
    '{8'h34, 16'h3333, 4'h4}, '{8'h24, 16'h3333, 4'h4}, '{8'h14, 16'h3333, 4'h8},
    '{8'h04, 16'h3333, 4'h8}, '{8'h40, 16'hB1E4, 4'h8}, '{8'h30, 16'h8D72, 4'h4}};
  logic        mclk_in = 1'b0;
  logic        rst_in  = 1'b1;
  logic        lclk    = 1'b0;
  logic        sclk    = 1'b0;
  logic        csb_n   = 1'b1;
  logic        sdio_tb = 1'b0;
  logic        strobe  = 1'b0;
  logic        tick    = 1'b0;
  logic [2:0]  lsync   = 3'h0;
  logic [2:0]  tcnt    = 3'h0;
  logic [15:0] data    = 16'hFFFF;
  logic [7:0]  fmt     = 8'h30;
  logic        sdio_in, sdio_out, sdio_oe, lane0, lane1, frame, dprst, pd;
  logic [3:0]  mult;
  logic        bclk;
  logic        b0;
  logic [15:0] word, wcnt;
  logic [7:0]  rd;
  logic        acc;
  int          failures = 0;
  int          samples_checked = 0;
  int          scnt;
  assign sdio_in = sdio_oe ? sdio_out : sdio_tb;
  always #2.5 mclk_in = ~mclk_in;
  always #24 lclk = ~lclk;
  always @(posedge mclk_in) begin
    lsync  <= {lsync[1:0], lclk};
    tick   <= lsync[2] ^ lsync[1];
    strobe <= (lsync[2] ^ lsync[1]) && tcnt == 3'h7;
    if (lsync[2] ^ lsync[1]) begin
      tcnt <= tcnt + 3'h1;
    end
  end
  aso_serial_ctrl #(.SETTLE_SAMPLES(SETTLE)) i_aso_serial_ctrl (
    .mclk_in(mclk_in), .rst_in(rst_in), .sclk_in(sclk), .csb_n_in(csb_n),
    .sdio_in(sdio_in), .sdio_out(sdio_out), .sdio_oe_out(sdio_oe),
    .sample_strobe_in(strobe), .sample_data_in(data), .bit_tick_in(tick),
    .lane0_out(lane0), .lane1_out(lane1), .frame_out(frame),
    .bit_clock_output_out(bclk), .clock_mult_out(mult),
    .datapath_reset_out(dprst), .common_mode_voltage_pd_out(pd));
  aso_capture_model i_aso_capture_model (
    .mclk_in(mclk_in), .rst_in(rst_in), .tick_in(tick), .fmt_in(fmt),
    .lane0_in(lane0), .lane1_in(lane1), .frame_in(frame),
    .word_out(word), .count_out(wcnt));
  // ====
  // Tasks
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      failures++;
      $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic spi(input logic r, input logic [12:0] a, input logic [7:0] d,
                     output logic [7:0] q);
    logic [23:0] f;
    f = {r, 2'b00, a, d};
    q = 8'h00;
    @(posedge mclk_in) csb_n <= 1'b0;
    for (int i = 23; i >= 0; i--) begin
      @(posedge mclk_in) sclk <= 1'b0;
      sdio_tb <= f[i];
      repeat (8) @(posedge mclk_in);
      if (i < 8) q[i] = sdio_in;
      sclk <= 1'b1;
      repeat (7) @(posedge mclk_in);
    end
    @(posedge mclk_in) sclk <= 1'b0;
    sdio_tb <= ~f[0];
    repeat (8) @(posedge mclk_in);
    csb_n <= 1'b1;
    repeat (8) @(posedge mclk_in);
  endtask : spi
  task automatic words(input int n);
    logic [15:0] c;
    c = wcnt + 16'(n);
    for (int k = 0; k < 5000 && wcnt !== c; k++) @(posedge mclk_in);
    chk(wcnt, c);
  endtask : words
  task automatic summarize();
    $display("Checks %0d, mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : summarize
  initial begin
    repeat (40000) @(posedge mclk_in);
    failures++;
    summarize();
  end
  // ====
  // Sequence
  initial begin
    acc = 1'b0;
    repeat (8) @(posedge mclk_in);
    rst_in <= 1'b0;
    @(posedge mclk_in);
    chk(mult, 4'h4);
    chk(dprst, 1'b0);
    chk(pd, 1'b0);
    do @(posedge mclk_in); while (!tick);
    b0 = bclk;
    @(posedge mclk_in);
    chk(bclk, !b0);
    repeat (200) begin
      @(posedge mclk_in);
      acc = acc | lane0 | lane1;
    end
    chk(acc, 1'b0);
    spi(1'b1, aso_pkg::ADDR_OUT_FORMAT, 8'h00, rd);
    chk(rd, 8'h30);
    spi(1'b1, aso_pkg::ADDR_CM_GEN, 8'h00, rd);
    chk(rd, 8'h00);
    foreach (rows[k]) begin
      data <= rows[k].data;
      spi(1'b0, aso_pkg::ADDR_OUT_FORMAT, rows[k].fmt, rd);
      fmt <= rows[k].fmt;
      spi(1'b1, aso_pkg::ADDR_OUT_FORMAT, 8'h00, rd);
      chk(rd, rows[k].fmt);
      words(3);
      chk(mult, rows[k].mult);
      chk(word, rows[k].data);
    end
    data <= 16'hFFFF;
    spi(1'b0, aso_pkg::ADDR_POWER_MODE, 8'h03, rd);
    chk(dprst, 1'b1);
    chk({lane0, lane1}, 2'b00);
    spi(1'b1, aso_pkg::ADDR_POWER_MODE, 8'h00, rd);
    chk(rd, 8'h03);
    spi(1'b0, aso_pkg::ADDR_POWER_MODE, 8'h00, rd);
    chk(dprst, 1'b0);
    acc  = 1'b0;
    scnt = 0;
    for (int k = 0; k < 20000 && scnt < SETTLE - 4; k++) begin
      @(posedge mclk_in);
      acc = acc | lane0 | lane1;
      scnt += int'(strobe);
    end
    chk(acc, 1'b0);
    words(8);
    chk(word, 16'hFFFF);
    spi(1'b0, aso_pkg::ADDR_CM_GEN, 8'hFF, rd);
    chk(pd, 1'b1);
    spi(1'b1, aso_pkg::ADDR_CM_GEN, 8'h00, rd);
    chk(rd, 8'h08);
    spi(1'b0, 13'h0055, 8'hFF, rd);
    spi(1'b1, 13'h0055, 8'h00, rd);
    chk(rd, 8'h00);
    spi(1'b0, aso_pkg::ADDR_CM_GEN, 8'h00, rd);
    chk(pd, 1'b0);
    // Power-down mode only silences the lanes; it is not a digital reset.
    spi(1'b0, aso_pkg::ADDR_POWER_MODE, 8'h01, rd);
    chk(dprst, 1'b0);
    acc = 1'b0;
    repeat (100) begin
      @(posedge mclk_in);
      acc = acc | lane0 | lane1;
    end
    chk(acc, 1'b0);
    spi(1'b0, aso_pkg::ADDR_POWER_MODE, 8'h00, rd);
    // A reset in mid-run must bring back the default format.
    spi(1'b0, aso_pkg::ADDR_OUT_FORMAT, 8'h40, rd);
    repeat (100) @(posedge mclk_in);
    chk(mult, 4'h8);
    rst_in <= 1'b1;
    repeat (8) @(posedge mclk_in);
    rst_in <= 1'b0;
    fmt    <= 8'h30;
    @(posedge mclk_in);
    chk(mult, 4'h4);
    spi(1'b1, aso_pkg::ADDR_OUT_FORMAT, 8'h00, rd);
    chk(rd, 8'h30);
    summarize();
  end
endmodule : tb_aso_serial_ctrl
